// ---- rtl/osc_ctrl_consts.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef OSC_CTRL_CONSTS_SVH
`define OSC_CTRL_CONSTS_SVH
`define STATUS_OFFSET 32'h0000000c
`define CONTROL_OFFSET 32'h00000010
`define INT_FLAG_OFFSET 32'h00000020
`define INT_MASK_OFFSET 32'h00000024
`define CONTROL_RESET 16'h0080
`define CONTROL_WMASK 16'hffc6
`define BIT_ENABLE 1
`define BIT_PAD_SEL 2
`define BIT_STANDBY_RUN 6
`define BIT_GATED_RUN 7
`define BIT_AUTO_GAIN 11
`define GAIN_LSB 8
`define GAIN_MSB 10
`define STARTUP_LSB 12
`define STARTUP_MSB 15
`define SYNC_CYCLES 2'h3
`define GAIN_MAX_LEGAL 3'h4
`endif

// ---- rtl/osc_ctrl_pkg.sv ----
// types shared by the oscillator control logic
package osc_ctrl_pkg;
  typedef enum logic [3:0] {
    OSC_OFF = 4'h1,
    OSC_COUNT = 4'h2,
    OSC_SYNC = 4'h4,
    OSC_READY = 4'h8
  } osc_state_t;
endpackage : osc_ctrl_pkg

// ---- rtl/crystal_oscillator_control.sv ----
// control, start-up sequencing and status for the main crystal oscillator
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`include "osc_ctrl_consts.svh"
// How it works
// - ready flag lives in status bit 0
// - start-up counts 2^n slow-clock ticks
// - three oscillator cycles sync before ready
// - auto gain bit enables amplitude control
// - gain field 3 bits, codes 5-7 reserved
// - gain field ignored under auto gain
// - gated mode runs only on request
// - ungated mode runs whenever enabled, except in standby without keep-running
// - standby without keep-running stops oscillator
// - standby with keep-running follows gating
// - pad select: external clock or crystal
// - enable bit turns oscillator on
// - ready rise sets sticky interrupt flag
module crystal_oscillator_control (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic slow_tick,
  input wire logic osc_clk_tick,
  input wire logic periph_clk_request,
  input wire logic standby_mode,
  output logic osc_run,
  output logic crystal_pad_select,
  output logic osc_output_pad_oe,
  output logic auto_gain_control_enable,
  output logic [2:0] osc_gain,
  output logic main_osc_ready_flag,
  output logic irq
);

  // ****************************************
  // register storage
  // ****************************************
  logic [15:0] control_reg;
  logic [15:0] control_next;
  logic int_flag_reg;
  logic int_flag_next;
  logic int_mask_reg;
  logic ready_reg;
  logic ready_prev_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [1:0] sync_reg;
  logic [1:0] sync_next;
  osc_ctrl_pkg::osc_state_t state_reg;
  osc_ctrl_pkg::osc_state_t state_next;

  // ****************************************
  // ahb-lite slave
  // ****************************************
  logic wr_pend_reg;
  logic [31:0] addr_reg;
  wire addr_phase = hsel & hready & htrans[1];
  wire hit_status = (addr_reg == `STATUS_OFFSET);
  wire hit_control = (addr_reg == `CONTROL_OFFSET);
  wire hit_flag = (addr_reg == `INT_FLAG_OFFSET);
  wire hit_mask = (addr_reg == `INT_MASK_OFFSET);
  wire wr_control = wr_pend_reg & hit_control;
  wire wr_flag = wr_pend_reg & hit_flag;
  wire wr_mask = wr_pend_reg & hit_mask;
  wire [31:0] rd_mux = hit_status ? {31'h0, ready_reg} :
    hit_control ? {16'h0, control_reg} :
    hit_flag ? {31'h0, int_flag_reg} :
    hit_mask ? {31'h0, int_mask_reg} : 32'h0;

  // capture address phase; writes land one cycle later with hwdata
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 32'h0;
    end else begin
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase) begin
        addr_reg <= haddr;
      end
    end
  end

  // read data registered: zero wait state would need combinational hrdata
  logic rd_pend_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_reg <= 1'b0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (addr_phase & ~hwrite) begin
        rd_pend_reg <= 1'b1;
        hreadyout <= 1'b0;
      end else if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        hrdata <= rd_mux;
        hreadyout <= 1'b1;
      end
    end
  end

  // ****************************************
  // control register
  // ****************************************
  // reserved gain codes fall back to the top legal code
  wire [2:0] gain_wr = hwdata[`GAIN_MSB:`GAIN_LSB];
  wire [2:0] gain_fix = (gain_wr > `GAIN_MAX_LEGAL) ? `GAIN_MAX_LEGAL : gain_wr;
  always_comb begin
    control_next = control_reg;
    if (wr_control) begin
      control_next = hwdata[15:0] & `CONTROL_WMASK;
      control_next[`GAIN_MSB:`GAIN_LSB] = gain_fix;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_reg <= `CONTROL_RESET;
    end else begin
      control_reg <= control_next;
    end
  end

  // ****************************************
  // run decision
  // ****************************************
  wire en_bit = control_reg[`BIT_ENABLE];
  wire gated = control_reg[`BIT_GATED_RUN];
  wire keep_sb = control_reg[`BIT_STANDBY_RUN];
  wire demand_ok = ~gated | periph_clk_request;
  wire standby_ok = ~standby_mode | keep_sb;
  wire run_want = en_bit & demand_ok & standby_ok;
  wire [3:0] startup_code = control_reg[`STARTUP_MSB:`STARTUP_LSB];
  wire [15:0] startup_last = 16'((17'h1 << startup_code) - 17'h1);

  // ****************************************
  // start-up sequencer
  // ****************************************
  // slow_tick counts the start-up, osc_clk_tick the sync delay
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    sync_next = sync_reg;
    case (state_reg)
      osc_ctrl_pkg::OSC_OFF: begin
        count_next = 16'h0;
        sync_next = 2'h0;
        if (run_want) begin
          state_next = osc_ctrl_pkg::OSC_COUNT;
        end
      end
      osc_ctrl_pkg::OSC_COUNT: begin
        if (slow_tick) begin
          if (count_reg == startup_last) begin
            state_next = osc_ctrl_pkg::OSC_SYNC;
          end else begin
            count_next = count_reg + 16'h1;
          end
        end
      end
      osc_ctrl_pkg::OSC_SYNC: begin
        if (osc_clk_tick) begin
          if (sync_reg == `SYNC_CYCLES - 2'h1) begin
            state_next = osc_ctrl_pkg::OSC_READY;
          end else begin
            sync_next = sync_reg + 2'h1;
          end
        end
      end
      osc_ctrl_pkg::OSC_READY: begin
        state_next = osc_ctrl_pkg::OSC_READY;
      end
      default: begin
        state_next = osc_ctrl_pkg::OSC_OFF;
      end
    endcase
    if (!run_want) begin
      state_next = osc_ctrl_pkg::OSC_OFF;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= osc_ctrl_pkg::OSC_OFF;
      count_reg <= 16'h0;
      sync_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      sync_reg <= sync_next;
    end
  end

  // ****************************************
  // status and interrupt
  // ****************************************
  wire ready_now = (state_next == osc_ctrl_pkg::OSC_READY);
  wire ready_rise = ready_reg & ~ready_prev_reg;
  // set wins over a same-cycle write-one clear
  always_comb begin
    int_flag_next = int_flag_reg;
    if (wr_flag & hwdata[0]) begin
      int_flag_next = 1'b0;
    end
    if (ready_rise) begin
      int_flag_next = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_reg <= 1'b0;
      ready_prev_reg <= 1'b0;
      int_flag_reg <= 1'b0;
      int_mask_reg <= 1'b0;
      irq <= 1'b0;
    end else begin
      ready_reg <= ready_now;
      ready_prev_reg <= ready_reg;
      int_flag_reg <= int_flag_next;
      if (wr_mask) begin
        int_mask_reg <= hwdata[0];
      end
      irq <= int_flag_next & (wr_mask ? hwdata[0] : int_mask_reg);
    end
  end

  // ****************************************
  // oscillator-facing outputs
  // ****************************************
  // gain is forced unused under auto control; analog side ignores it too
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_run <= 1'b0;
      crystal_pad_select <= 1'b0;
      osc_output_pad_oe <= 1'b0;
      auto_gain_control_enable <= 1'b0;
      osc_gain <= 3'h0;
      main_osc_ready_flag <= 1'b0;
    end else begin
      osc_run <= run_want;
      crystal_pad_select <= control_next[`BIT_PAD_SEL];
      osc_output_pad_oe <= control_next[`BIT_PAD_SEL] & run_want;
      auto_gain_control_enable <= control_next[`BIT_AUTO_GAIN] & run_want;
      osc_gain <= control_next[`BIT_AUTO_GAIN] ? 3'h0 :
        control_next[`GAIN_MSB:`GAIN_LSB];
      main_osc_ready_flag <= ready_now;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_ready_needs_run;
    @(posedge hclk) disable iff (!hresetn) ready_reg |-> $past(run_want);
  endproperty
  a_ready_needs_run: assert property (p_ready_needs_run) else $error("ready without run");

  property p_stop_clears;
    @(posedge hclk) disable iff (!hresetn) !run_want |=> !ready_reg;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("ready kept after stop");

  property p_irq_rise;
    @(posedge hclk) disable iff (!hresetn) ready_rise |=> int_flag_reg;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("flag not set");

  property p_gain_ignored;
    @(posedge hclk) disable iff (!hresetn) control_reg[`BIT_AUTO_GAIN] |-> osc_gain == 3'h0;
  endproperty
  a_gain_ignored: assert property (p_gain_ignored) else $error("gain used under auto");

  property p_gain_legal;
    @(posedge hclk) disable iff (!hresetn) control_reg[`GAIN_MSB:`GAIN_LSB] <= `GAIN_MAX_LEGAL;
  endproperty
  a_gain_legal: assert property (p_gain_legal) else $error("reserved gain");

  property p_standby_off;
    @(posedge hclk) disable iff (!hresetn) (standby_mode && !keep_sb) |=> !osc_run;
  endproperty
  a_standby_off: assert property (p_standby_off) else $error("runs in standby");

  property p_gated_off;
    @(posedge hclk) disable iff (!hresetn) (gated && !periph_clk_request) |=> !osc_run;
  endproperty
  a_gated_off: assert property (p_gated_off) else $error("runs without request");

  property p_sync_wait;
    @(posedge hclk) disable iff (!hresetn)
      $rose(state_reg == osc_ctrl_pkg::OSC_SYNC) |-> !ready_reg [*3];
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("ready too early");

endmodule : crystal_oscillator_control

// ---- tb/osc_source_model.sv ----
// partner model: crystal source and low-power slow clock as tick pulses
`timescale 1ns/1ns
module osc_source_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic osc_run,
  output logic slow_tick,
  output logic osc_clk_tick
);
  // ************************************
  // tick generation
  // ************************************
  logic [3:0] slow_cnt_reg;
  logic [1:0] osc_cnt_reg;
  // a stopped crystal gives no cycles; phases restart with each run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_cnt_reg <= 4'h0;
      osc_cnt_reg <= 2'h0;
    end else if (!osc_run) begin
      slow_cnt_reg <= 4'h0;
      osc_cnt_reg <= 2'h0;
    end else begin
      slow_cnt_reg <= slow_cnt_reg + 4'h1;
      osc_cnt_reg <= (osc_cnt_reg == 2'h2) ? 2'h0 : osc_cnt_reg + 2'h1;
    end
  end
  // slow tick every 16 cycles, far slower than the 3-cycle oscillator tick
  assign slow_tick = osc_run && (slow_cnt_reg == 4'hf);
  assign osc_clk_tick = osc_run && (osc_cnt_reg == 2'h2);
endmodule : osc_source_model

// ---- tb/crystal_oscillator_control_test.sv ----
// self-checking bench for the crystal oscillator control block
`timescale 1ns/1ns
`include "osc_ctrl_consts.svh"
module crystal_oscillator_control_test;
  // ************************************
  // signals, design and partner
  // ************************************
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow_tick, osc_clk_tick;
  logic periph_clk_request, standby_mode, osc_run, crystal_pad_select, osc_output_pad_oe;
  logic auto_gain_control_enable, main_osc_ready_flag, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, osc_gain;
  int err_total, cmp_count, ticks;
  crystal_oscillator_control crystal_oscillator_control_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .slow_tick(slow_tick), .osc_clk_tick(osc_clk_tick),
    .periph_clk_request(periph_clk_request), .standby_mode(standby_mode),
    .osc_run(osc_run), .crystal_pad_select(crystal_pad_select),
    .osc_output_pad_oe(osc_output_pad_oe), .auto_gain_control_enable(auto_gain_control_enable),
    .osc_gain(osc_gain), .main_osc_ready_flag(main_osc_ready_flag), .irq(irq));
  osc_source_model osc_source_model_i (.hclk(hclk), .hresetn(hresetn), .osc_run(osc_run),
    .slow_tick(slow_tick), .osc_clk_tick(osc_clk_tick));
  // start-up ticks seen while waiting for ready
  always @(posedge hclk) if (osc_run && !main_osc_ready_flag && slow_tick) ticks <= ticks + 1;
  // ************************************
  // bus and check tasks
  // ************************************
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk
  // outputs are registered behind the control register, so let them land
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    repeat (3) @(posedge hclk);
  endtask : wr
  task automatic wait_ready;
    int n;
    n = 0;
    while (main_osc_ready_flag !== 1'b1 && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    // a start-up that never ends must count as a mismatch
    chk(main_osc_ready_flag, 1'b1);
  endtask : wait_ready
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // ************************************
  // clock, watchdog and test sequence
  // ************************************
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    #400000;
    err_total++;
    stop_test();
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; periph_clk_request = 1'b0; standby_mode = 1'b0; ticks = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(`CONTROL_OFFSET, 32'h00000080);
    rchk(`STATUS_OFFSET, 32'h0);
    rchk(32'h00000040, 32'h0);
    wr(`INT_MASK_OFFSET, 32'h1);
    ticks = 0;
    wr(`CONTROL_OFFSET, 32'h00002306);
    chk(osc_run, 1'b1);
    chk(osc_output_pad_oe & crystal_pad_select, 1'b1);
    chk(osc_gain, 3'h3);
    wait_ready();
    chk(ticks, 4);
    rchk(`STATUS_OFFSET, 32'h1);
    chk(irq, 1'b1);
    wr(`INT_FLAG_OFFSET, 32'h0);
    rchk(`INT_FLAG_OFFSET, 32'h1);
    wr(`INT_FLAG_OFFSET, 32'h1);
    chk(irq, 1'b0);
    wr(`CONTROL_OFFSET, 32'h00002b06);
    chk(auto_gain_control_enable, 1'b1);
    chk(osc_gain, 3'h0);
    wr(`CONTROL_OFFSET, 32'h00000702);
    chk(osc_gain, 3'h4);
    chk(osc_output_pad_oe | crystal_pad_select, 1'b0);
    wr(`CONTROL_OFFSET, 32'h00000082);
    chk(osc_run | main_osc_ready_flag, 1'b0);
    ticks = 0;
    periph_clk_request <= 1'b1;
    wait_ready();
    chk(ticks, 1);
    wr(`INT_MASK_OFFSET, 32'h0);
    chk(irq, 1'b0);
    rchk(`INT_FLAG_OFFSET, 32'h1);
    standby_mode <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(osc_run | main_osc_ready_flag, 1'b0);
    wr(`CONTROL_OFFSET, 32'h000000c2);
    chk(osc_run, 1'b1);
    periph_clk_request <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(osc_run, 1'b0);
    wr(`CONTROL_OFFSET, 32'h00000042);
    chk(osc_run, 1'b1);
    wr(`CONTROL_OFFSET, 32'h00000040);
    chk(osc_run, 1'b0);
    stop_test();
  end
endmodule : crystal_oscillator_control_test
